// >>> bench/mpa_link_monitor.sv
// Purpose: checks on the arbitration link
// Assumes: one processor end and one host end on the link
// Notes:   link signals come in as plain inputs
`timescale 1ns/10ps
`default_nettype none
module mpa_link_monitor (
	input wire logic       CLOCK,
	input wire logic       RESET_N,
	input wire logic [7:0] dev_br_oe,
	input wire logic       dev_hbg_o,
	input wire logic       dev_hbg_oe,
	input wire logic       dev_cpa_o,
	input wire logic       dev_cpa_oe,
	input wire logic       dev_dpa_oe,
	input wire logic       bm_n,
	input wire logic       lock_n,
	input wire logic       hbr_n,
	input wire logic       hbg_n,
	input wire logic [7:0] br_n,
	input wire logic [2:0] id
);
	default clocking @(posedge CLOCK);
	endclocking
	default disable iff (!RESET_N);
	a_own_line_only: assert property (dev_br_oe != 8'h00 |-> dev_br_oe == (8'h01 << id))
		else $error("foreign request line driven");
	a_release_gap: assert property ($fell(dev_br_oe[id]) |=> (!dev_br_oe[id]) [*2])
		else $error("request line not left high after release");
	a_master_seen_req: assert property ($fell(bm_n) |-> !br_n[id] && !$past(br_n[id], 3))
		else $error("master without own request seen");
	a_lock_by_master: assert property (!lock_n |-> !bm_n)
		else $error("lock shown by non-master");
	a_grant_on_req: assert property ($fell(dev_hbg_o) |-> dev_hbg_oe && !hbr_n && !$past(hbr_n, 2))
		else $error("grant without host request");
	a_grant_held: assert property ($rose(dev_hbg_o) |-> hbr_n && $past(hbg_n) == 1'b0)
		else $error("grant dropped while requested");
	a_grant_owner: assert property (dev_hbg_oe |-> !bm_n)
		else $error("grant driven by a slave");
	a_prio_pull: assert property (dev_cpa_oe |-> !dev_cpa_o && !dev_dpa_oe)
		else $error("priority pull wrong");
	a_host_rerequest: assert property ($fell(hbr_n) |-> hbg_n && $past(hbg_n))
		else $error("host request while grant low");
endmodule : mpa_link_monitor
`default_nettype wire

// >>> bench/tb_multiprocessor_bus_arbitration.sv
// Purpose: bench for both arbitration ends on one link
// Assumes: bench plays the other processors through the ext lines
// Notes:   inputs move on the falling edge; waits are bounded
`timescale 1ns/10ps
`default_nettype none
module tb_multiprocessor_bus_arbitration;
	import mpa_pkg::*;
	logic      clock = 0;
	logic      reset_n = 0;
	logic      req, lock, active, sr_ack, host_req, host_host_backoff;
	logic      bus_oe, sr_req, abort_p, host_own;
	mpa_kind_t kind;
	int        checks = 0;
	int        miscompares = 0;
	mpa_link_if lnk();
	mpa_proc_end mpa_proc_end_inst (.CLOCK(clock), .RESET_N(reset_n), .LINK(lnk), .REQ(req),
		.KIND(kind), .LOCK(lock), .ACTIVE(active), .SR_ACK(sr_ack), .BUS_OE(bus_oe),
		.SR_REQ(sr_req), .ABORT(abort_p));
	mpa_host_end mpa_host_end_inst (.CLOCK(clock), .RESET_N(reset_n), .LINK(lnk),
		.HOST_REQ(host_req), .HOST_BACKOFF(host_host_backoff), .HOST_OWN(host_own));
	mpa_link_monitor mpa_link_monitor_inst (.CLOCK(clock), .RESET_N(reset_n),
		.dev_br_oe(lnk.dev_br_oe), .dev_hbg_o(lnk.dev_hbg_o), .dev_hbg_oe(lnk.dev_hbg_oe),
		.dev_cpa_o(lnk.dev_cpa_o), .dev_cpa_oe(lnk.dev_cpa_oe), .dev_dpa_oe(lnk.dev_dpa_oe),
		.bm_n(lnk.bm_n), .lock_n(lnk.lock_n), .hbr_n(lnk.hbr_n), .hbg_n(lnk.hbg_n),
		.br_n(lnk.br_n), .id(lnk.id));
	initial begin
		forever #5 clock = ~clock;
	end
	task complete_run();
		$display("checks %0d miscompares %0d", checks, miscompares);
		if (miscompares == 0 && checks > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask : complete_run
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		checks++;
		if (got !== exp) begin
			miscompares++;
			$display("BAD %0t got %h want %h", $time, got, exp);
		end
	endtask : chk
	task automatic tick(input int n);
		repeat (n) @(negedge clock);
	endtask : tick
	function automatic logic pick(input int w);
		case (w)
			0: return bus_oe;
			1: return sr_req;
			2: return host_own;
			3: return abort_p;
			default: return lnk.hbg_n;
		endcase
	endfunction : pick
	// bounded wait, then judge the level reached
	task automatic upto(input int w, input logic v);
		for (int i = 0; i < 40 && pick(w) !== v; i++) tick(1);
		chk(pick(w), v);
	endtask : upto
	// identity may only move while reset is held
	task automatic boot(input logic [2:0] n);
		reset_n = 0;
		lnk.id = n;
		tick(6);
		reset_n = 1;
		tick(4);
	endtask : boot
	task automatic grab(input logic [2:0] n, input mpa_kind_t k);
		kind = k;
		req = 1;
		upto(0, 1);
		chk(lnk.dev_br_oe, 8'h01 << n);
		chk(lnk.bm_n, 0);
		chk(lnk.dev_cpa_oe, k == KIND_CORE);
		chk(lnk.dev_dpa_oe, k == KIND_DMA_HI);
	endtask : grab
	task automatic drop();
		req = 0;
		lock = 0;
		active = 0;
		upto(0, 0);
		chk(lnk.bm_n, 1);
		tick(1);
	endtask : drop
	task automatic t_ids();
		for (int n = 0; n < 8; n++) begin
			boot(n[2:0]);
			grab(n[2:0], mpa_kind_t'(n[1:0]));
			drop();
		end
	endtask : t_ids
	task automatic t_arb();
		boot(3'h5);
		lnk.ext_br_n = 8'hFB;
		lnk.ext_hbg_n = 0;
		kind = KIND_CORE;
		req = 1;
		tick(20);
		chk(bus_oe, 0);
		chk(lnk.br_n, 8'hDB);
		lnk.ext_br_n = 8'hFF;
		tick(8);
		chk(bus_oe, 0);
		lnk.ext_hbg_n = 1;
		upto(0, 1);
		drop();
	endtask : t_arb
	task automatic t_host();
		grab(3'h5, KIND_CORE);
		active = 1;
		host_req = 1;
		tick(12);
		chk(bus_oe, 1);
		active = 0;
		upto(1, 1);
		chk(bus_oe, 0);
		tick(5);
		chk(lnk.hbg_n, 1);
		sr_ack = 1;
		upto(2, 1);
		tick(10);
		chk(lnk.hbg_n, 0);
		host_req = 0;
		upto(4, 1);
		upto(1, 0);
		sr_ack = 0;
		upto(0, 1);
		drop();
	endtask : t_host
	task automatic t_host_backoff();
		grab(3'h5, KIND_CORE);
		active = 1;
		host_req = 1;
		host_host_backoff = 1;
		upto(3, 1);
		chk(bus_oe, 0);
		host_host_backoff = 0;
		active = 0;
		sr_ack = 1;
		upto(2, 1);
		host_req = 0;
		upto(1, 0);
		sr_ack = 0;
		drop();
	endtask : t_host_backoff
	// a slave pulls one priority line; master yields or keeps the bus
	task automatic t_pre(input mpa_kind_t k, input logic l, input logic core_priority_line, input logic y);
		grab(3'h5, k);
		lock = l;
		lnk.ext_cpa_n = !core_priority_line;
		lnk.ext_dpa_n = core_priority_line;
		tick(12);
		chk(bus_oe, !y);
		if (l) chk(lnk.lock_n, 0);
		lnk.ext_cpa_n = 1;
		lnk.ext_dpa_n = 1;
		drop();
	endtask : t_pre
	initial begin
		{req, lock, active, sr_ack, host_req, host_host_backoff} = '0;
		kind = KIND_CORE;
		lnk.ext_br_n = 8'hFF;
		{lnk.ext_hbg_n, lnk.ext_cpa_n, lnk.ext_dpa_n} = 3'h7;
		t_ids();
		t_arb();
		t_host();
		t_host_backoff();
		t_pre(KIND_DMA_BG, 0, 1, 1);
		t_pre(KIND_DMA_NORM, 0, 0, 1);
		t_pre(KIND_DMA_NORM, 0, 1, 0);
		t_pre(KIND_DMA_BG, 1, 1, 0);
		t_pre(KIND_CORE, 0, 1, 0);
		complete_run();
	end
	// whole run needs a few hundred cycles; this cuts a hang
	initial begin
		#100000;
		miscompares++;
		complete_run();
	end
endmodule : tb_multiprocessor_bus_arbitration
`default_nettype wire

// >>> include/mpa_link_if.sv
// Purpose: link between one processor end, the host end and the other processors
// Assumes: ext_* signals are driven by the testbench for the absent parties
// Notes:   open-drain and shared lines are resolved here, idle level high
`timescale 1ns/10ps
`default_nettype none
interface mpa_link_if;
	import mpa_pkg::*;

	logic [NUM_PROC-1:0] dev_br_oe;
	logic                dev_br_o;
	logic                dev_hbg_o;
	logic                dev_hbg_oe;
	logic                dev_cpa_o;
	logic                dev_cpa_oe;
	logic                dev_dpa_o;
	logic                dev_dpa_oe;
	logic                bm_n;
	logic                lock_n;
	logic                hbr_n;
	logic                host_backoff_n;
	logic [ID_W-1:0]     id;
	logic [NUM_PROC-1:0] ext_br_n;
	logic                ext_hbg_n;
	logic                ext_cpa_n;
	logic                ext_dpa_n;
	logic [NUM_PROC-1:0] br_n;
	logic                hbg_n;
	logic                cpa_n;
	logic                dpa_n;

	// wired-AND: any driver pulling low wins, no driver reads high
	always_comb begin
		for (int i = 0; i < NUM_PROC; i++) begin
			br_n[i] = (dev_br_oe[i] ? dev_br_o : 1'b1) & ext_br_n[i];
		end
		hbg_n = (dev_hbg_oe ? dev_hbg_o : 1'b1) & ext_hbg_n;
		cpa_n = (dev_cpa_oe ? dev_cpa_o : 1'b1) & ext_cpa_n;
		dpa_n = (dev_dpa_oe ? dev_dpa_o : 1'b1) & ext_dpa_n;
	end

	modport proc (
		output dev_br_oe, dev_br_o, dev_hbg_o, dev_hbg_oe,
		output dev_cpa_o, dev_cpa_oe, dev_dpa_o, dev_dpa_oe, bm_n, lock_n,
		input  br_n, hbr_n, host_backoff_n, hbg_n, cpa_n, dpa_n, id
	);

	modport host (
		output hbr_n, host_backoff_n,
		input  hbg_n
	);

endinterface : mpa_link_if
`default_nettype wire

// >>> include/mpa_pkg.sv
// Purpose: shared constants and types for the multiprocessor bus arbitration ends
// Assumes: eight processors, one host, active-low link signals
// Notes:   link lines idle high; a low level means asserted
package mpa_pkg;

	localparam int              NUM_PROC    = 8;
	localparam int              ID_W        = 3;
	localparam int              SYNC_W      = NUM_PROC + 5 + ID_W;
	localparam logic [ID_W-1:0] PARK_ID_RST = 3'h0;
	localparam logic [1:0]      INIT_CYCLES = 2'h3;
	localparam logic [SYNC_W-1:0] SYNC_RST  = 16'hFFF8;

	// kind of access the processor wants the bus for
	typedef enum logic [1:0] {
		KIND_CORE     = 2'b00,
		KIND_DMA_HI   = 2'b01,
		KIND_DMA_NORM = 2'b10,
		KIND_DMA_BG   = 2'b11
	} mpa_kind_t;

	typedef enum logic [2:0] {
		ST_IDLE    = 3'b000,
		ST_REQ     = 3'b001,
		ST_OWN     = 3'b010,
		ST_YIELD   = 3'b011,
		ST_SELFREF = 3'b100,
		ST_HGRANT  = 3'b101
	} mpa_state_t;

	typedef enum logic [1:0] {
		H_IDLE = 2'b00,
		H_WAIT = 2'b01,
		H_OWN  = 2'b10,
		H_DONE = 2'b11
	} mpa_hstate_t;

endpackage : mpa_pkg

// >>> rtl/mpa_host_end.sv
// Purpose: host end that requests the processors' shared bus
// Assumes: user ports on CLOCK; grant pin arrives from another domain
// Notes:   a new request waits until the previous grant has gone away
`timescale 1ns/10ps
`default_nettype none
module mpa_host_end (
	input  wire logic CLOCK,
	input  wire logic RESET_N,
	mpa_link_if.host  LINK,
	input  wire logic HOST_REQ,
	input  wire logic HOST_BACKOFF,
	output logic      HOST_OWN
);
	import mpa_pkg::*;

	logic        hbg1_q;
	logic        hbg2_q;
	mpa_hstate_t state_q;
	mpa_hstate_t state_d;
	logic        hbr_n_q;
	logic        hbr_n_d;
	logic        host_backoff_n_q;
	logic        host_backoff_n_d;
	logic        own_q;
	logic        own_d;

	always_ff @(posedge CLOCK or negedge RESET_N) begin
		if (!RESET_N) begin
			hbg1_q <= 1'b1;
			hbg2_q <= 1'b1;
		end else begin
			hbg1_q <= LINK.hbg_n;
			hbg2_q <= hbg1_q;
		end
	end

	always_comb begin
		state_d = state_q;
		case (state_q)
			H_IDLE: begin
				if (HOST_REQ) begin
					state_d = H_WAIT;
				end
			end
			H_WAIT: begin
				if (!HOST_REQ) begin
					state_d = H_DONE;
				end else if (!hbg2_q) begin
					state_d = H_OWN;
				end
			end
			H_OWN: begin
				if (!HOST_REQ) begin
					state_d = H_DONE;
				end
			end
			H_DONE: begin
				if (hbg2_q) begin
					state_d = H_IDLE;
				end
			end
			default: begin
				state_d = H_IDLE;
			end
		endcase
		hbr_n_d  = !((state_d == H_WAIT) || (state_d == H_OWN));
		// back-off only helps while still waiting on a deadlocked master
		host_backoff_n_d = !(HOST_BACKOFF && (state_d == H_WAIT));
		own_d    = (state_d == H_OWN);
	end

	always_ff @(posedge CLOCK or negedge RESET_N) begin
		if (!RESET_N) begin
			state_q  <= H_IDLE;
			hbr_n_q  <= 1'b1;
			host_backoff_n_q <= 1'b1;
			own_q    <= 1'b0;
		end else begin
			state_q  <= state_d;
			hbr_n_q  <= hbr_n_d;
			host_backoff_n_q <= host_backoff_n_d;
			own_q    <= own_d;
		end
	end

	assign LINK.hbr_n  = hbr_n_q;
	assign LINK.host_backoff_n = host_backoff_n_q;
	assign HOST_OWN    = own_q;

endmodule : mpa_host_end
`default_nettype wire

// >>> rtl/mpa_proc_end.sv
// Purpose: bus arbitration end of one processor in a shared external bus system
// Assumes: identity pins stable while out of reset; user ports on CLOCK
// Notes:   lowest identity among requesters wins a free bus; bus parks at the last owner, id 0 after reset
//
// Contract
// - drive own request line, watch all others
// - identity n selects request line n
// - identity pins change only during reset
// - absent processors' request lines held high
// - bus owner asserts master indicator, debug only
// - back-off makes master drop bus, abandon transaction
// - output shows master has locked bus
// - host asserts host bus request for bus
// - master finishes transaction, releases, then grants host
// - master tri-states all shared bus outputs
// - master puts SDRAM in self-refresh first
// - grant held until host removes request
// - only master drives host grant; slaves monitor
// - core-priority line asserted during core access
// - core priority pre-empts master background DMA
// - DMA-priority line asserted during high-priority DMA
// - DMA priority pre-empts master normal DMA
`timescale 1ns/10ps
`default_nettype none
module mpa_proc_end (
	input  wire logic       CLOCK,
	input  wire logic       RESET_N,
	mpa_link_if.proc        LINK,
	input  wire logic       REQ,
	input  wire mpa_pkg::mpa_kind_t KIND,
	input  wire logic       LOCK,
	input  wire logic       ACTIVE,
	input  wire logic       SR_ACK,
	output logic            BUS_OE,
	output logic            SR_REQ,
	output logic            ABORT
);
	import mpa_pkg::*;

	logic [SYNC_W-1:0]   sync1_q;
	logic [SYNC_W-1:0]   sync2_q;
	logic [NUM_PROC-1:0] br_s;
	logic                hbr_s;
	logic                host_backoff_s;
	logic                hbg_s;
	logic                cpa_s;
	logic                dpa_s;
	logic [ID_W-1:0]     id_s;

	logic [1:0]          init_q;
	logic [1:0]          init_d;
	logic [ID_W-1:0]     id_q;
	logic [ID_W-1:0]     id_d;
	logic [ID_W-1:0]     master_q;
	logic [ID_W-1:0]     master_d;
	logic [ID_W-1:0]     low_id;
	logic                any_req;
	mpa_state_t          state_q;
	mpa_state_t          state_d;

	logic [NUM_PROC-1:0] br_oe_q;
	logic [NUM_PROC-1:0] br_oe_d;
	logic                bus_oe_q;
	logic                bus_oe_d;
	logic                bm_q;
	logic                bm_d;
	logic                hbg_o_q;
	logic                hbg_o_d;
	logic                sr_req_q;
	logic                sr_req_d;
	logic                lock_n_q;
	logic                lock_n_d;
	logic                cpa_oe_q;
	logic                cpa_oe_d;
	logic                dpa_oe_q;
	logic                dpa_oe_d;
	logic                abort_q;
	logic                abort_d;

	logic                init_done;
	logic                want;
	logic                preempt;
	logic                requesting;

	// pins pass two flops; only the second stage feeds logic
	always_ff @(posedge CLOCK or negedge RESET_N) begin
		if (!RESET_N) begin
			sync1_q <= SYNC_RST;
			sync2_q <= SYNC_RST;
		end else begin
			sync1_q <= {LINK.br_n, LINK.hbr_n, LINK.host_backoff_n, LINK.hbg_n,
			            LINK.cpa_n, LINK.dpa_n, LINK.id};
			sync2_q <= sync1_q;
		end
	end

	always_comb begin
		{br_s, hbr_s, host_backoff_s, hbg_s, cpa_s, dpa_s, id_s} = sync2_q;
	end

	always_comb begin
		init_done = (init_q == INIT_CYCLES);
		want      = REQ | LOCK;
		// lock keeps the bus from other processors only
		preempt   = !LOCK &
		            (((KIND == KIND_DMA_BG) & !cpa_s) |
		             ((KIND == KIND_DMA_NORM) & !dpa_s));
		// lowest identity among asserted lines; unused lines sit high
		low_id  = PARK_ID_RST;
		any_req = !(&br_s);
		for (int i = NUM_PROC - 1; i >= 0; i--) begin
			if (!br_s[i]) begin
				low_id = i[ID_W-1:0];
			end
		end
	end

	// identity is caught once after reset release, never while running
	always_comb begin
		init_d = init_q;
		id_d   = id_q;
		if (!init_done) begin
			init_d = init_q + 2'h1;
			id_d   = id_s;
		end
	end

	// every processor tracks the owner from the same sampled lines
	always_comb begin
		master_d = master_q;
		if (init_done && hbg_s && br_s[master_q] && any_req) begin
			master_d = low_id;
		end
	end

	always_comb begin
		state_d = state_q;
		abort_d = 1'b0;
		case (state_q)
			ST_IDLE: begin
				// wait until our own release has come through the sync, else a stale low
				// sample of our line would look like the bus is still ours
				if (want && init_done && br_s[id_q]) begin
					state_d = ST_REQ;
				end
			end
			ST_REQ: begin
				if (!want) begin
					state_d = ST_IDLE;
				end else if ((master_q == id_q) && !br_s[id_q] && hbg_s) begin
					state_d = ST_OWN;
				end
			end
			ST_OWN: begin
				if (!host_backoff_s) begin
					abort_d = 1'b1;
					state_d = ST_SELFREF;
				end else if (!ACTIVE) begin
					if (!hbr_s) begin
						state_d = ST_SELFREF;
					end else if (preempt) begin
						state_d = ST_YIELD;
					end else if (!want) begin
						state_d = ST_IDLE;
					end
				end
			end
			ST_YIELD: begin
				// stay off the line until the priority request is served
				if (!want) begin
					state_d = ST_IDLE;
				end else if (cpa_s && dpa_s && br_s[id_q]) begin
					state_d = ST_REQ;
				end
			end
			ST_SELFREF: begin
				if (SR_ACK) begin
					state_d = hbr_s ? ST_OWN : ST_HGRANT;
				end
			end
			ST_HGRANT: begin
				if (hbr_s) begin
					state_d = ST_OWN;
				end
			end
			default: begin
				state_d = ST_IDLE;
			end
		endcase
	end

	// outputs follow the next state so each one leaves a flop
	always_comb begin
		requesting = (state_d == ST_REQ) || (state_d == ST_OWN) ||
		             (state_d == ST_SELFREF) || (state_d == ST_HGRANT);
		bm_d       = (state_d == ST_OWN) || (state_d == ST_SELFREF) ||
		             (state_d == ST_HGRANT);
		br_oe_d    = '0;
		if (requesting) begin
			br_oe_d[id_q] = 1'b1;
		end
		bus_oe_d   = (state_d == ST_OWN);
		sr_req_d   = (state_d == ST_SELFREF) || (state_d == ST_HGRANT);
		hbg_o_d    = !(state_d == ST_HGRANT);
		lock_n_d   = !(bm_d && LOCK);
		cpa_oe_d   = init_done && REQ && (KIND == KIND_CORE);
		dpa_oe_d   = init_done && REQ && (KIND == KIND_DMA_HI);
	end

	always_ff @(posedge CLOCK or negedge RESET_N) begin
		if (!RESET_N) begin
			init_q   <= 2'h0;
			id_q     <= PARK_ID_RST;
			master_q <= PARK_ID_RST;
			state_q  <= ST_IDLE;
			br_oe_q  <= '0;
			bus_oe_q <= 1'b0;
			bm_q     <= 1'b0;
			hbg_o_q  <= 1'b1;
			sr_req_q <= 1'b0;
			lock_n_q <= 1'b1;
			cpa_oe_q <= 1'b0;
			dpa_oe_q <= 1'b0;
			abort_q  <= 1'b0;
		end else begin
			init_q   <= init_d;
			id_q     <= id_d;
			master_q <= master_d;
			state_q  <= state_d;
			br_oe_q  <= br_oe_d;
			bus_oe_q <= bus_oe_d;
			bm_q     <= bm_d;
			hbg_o_q  <= hbg_o_d;
			sr_req_q <= sr_req_d;
			lock_n_q <= lock_n_d;
			cpa_oe_q <= cpa_oe_d;
			dpa_oe_q <= dpa_oe_d;
			abort_q  <= abort_d;
		end
	end

	// request and priority lines only pull low; the master drives host grant high as well as low
	assign LINK.dev_br_oe  = br_oe_q;
	assign LINK.dev_br_o   = 1'b0;
	assign LINK.dev_hbg_oe = bm_q;
	assign LINK.dev_hbg_o  = hbg_o_q;
	assign LINK.dev_cpa_oe = cpa_oe_q;
	assign LINK.dev_cpa_o  = 1'b0;
	assign LINK.dev_dpa_oe = dpa_oe_q;
	assign LINK.dev_dpa_o  = 1'b0;
	assign LINK.bm_n       = !bm_q;
	assign LINK.lock_n     = lock_n_q;
	assign BUS_OE          = bus_oe_q;
	assign SR_REQ          = sr_req_q;
	assign ABORT           = abort_q;

endmodule : mpa_proc_end
`default_nettype wire
